// [rtl/smb_client.sv]
`timescale 1ns/100ps
module smb_client
  import smb_client_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int IDLE_CYCLES = IDLE_CYC,
  parameter bit DEVICE_VARIANT = 1'b0,
  parameter int FIFO_DEPTH = WQ_DEPTH
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic serial_clock_pin, // Bus clock from host, asynchronous
  input wire logic sda_in, // Data line level, asynchronous
  output logic sda_out, // Data line drive level
  output logic sda_oe, // High while pulling data line
  input wire logic timeout_enable, // Clock-low time-out enable
  input wire logic deepest_sleep_request, // Deep sleep, idle reset off
  input wire logic hold_writes, // Core stalls register writes
  output logic wr_strobe, // One-cycle register write
  output logic [REG_AW-1:0] wr_addr, // Register written
  output logic [REG_W-1:0] wr_data, // Value written
  output logic ready, // Power-up quiet time over
  output logic addressed // Transfer aimed at this device
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [CNT_W-1:0] pwr_cnt;
    logic pwr_done;
    logic to_en;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] idle_cnt;
    proto_state_t state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [REG_AW-1:0] ptr;
    logic rw;
    logic more;
    logic oe;
    logic lvl;
    logic push_v;
    logic [WQ_W-1:0] push_word;
    logic wr_stb;
    logic [REG_AW-1:0] wr_addr;
    logic [REG_W-1:0] wr_data;
    logic addressed;
  } client_st_t;

  client_st_t st_r;
  client_st_t st_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_end;
  logic to_fire;
  logic idle_fire;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WQ_W-1:0] fifo_out_data;
  logic drain;
  logic [REG_W-1:0] mem_rdata;

  function automatic logic [REG_AW-1:0] inc_ptr(input logic [REG_AW-1:0] p);
    inc_ptr = p + 1'b1;
  endfunction : inc_ptr

  function automatic logic addr_hit(input logic [6:0] a);
    addr_hit = (a == (DEVICE_VARIANT ? ADDR_VARIANT2 : ADDR_VARIANT1));
  endfunction : addr_hit

  // Edges come from the second and third sampling stages only
  assign scl_rise = st_r.scl_s && !st_r.scl_d;
  assign scl_fall = !st_r.scl_s && st_r.scl_d;
  assign start_ev = st_r.scl_s && st_r.scl_d && st_r.sda_d && !st_r.sda_s;
  assign stop_ev = st_r.scl_s && st_r.scl_d && !st_r.sda_d && st_r.sda_s;
  assign byte_end = scl_fall && st_r.cnt == BITS_PER_BYTE;
  assign to_fire = st_r.to_en && st_r.low_cnt == CNT_W'(TIMEOUT_CYCLES - 1);
  assign idle_fire = !deepest_sleep_request && st_r.idle_cnt == CNT_W'(IDLE_CYCLES - 1);
  assign drain = fifo_out_valid && !hold_writes;

  assign sda_out = st_r.lvl;
  assign sda_oe = st_r.oe;
  assign wr_strobe = st_r.wr_stb;
  assign wr_addr = st_r.wr_addr;
  assign wr_data = st_r.wr_data;
  assign ready = st_r.pwr_done;
  assign addressed = st_r.addressed;

  // Received bytes queue here; the core may stall the drain, and the
  // bus never waits for it because the clock is never stretched.
  byte_fifo #(
    .W(WQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(st_r.push_v),
    .in_ready(fifo_in_ready),
    .in_data(st_r.push_word),
    .out_valid(fifo_out_valid),
    .out_ready(!hold_writes),
    .out_data(fifo_out_data)
  );

  reg_shadow_mem #(
    .AW(REG_AW),
    .W(REG_W)
  ) u_regs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wr_en(drain),
    .wr_addr(fifo_out_data[WQ_W-1:REG_W]),
    .wr_data(fifo_out_data[REG_W-1:0]),
    .rd_addr(st_r.ptr),
    .rd_data(mem_rdata)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.scl_m = serial_clock_pin;
    st_nxt.scl_s = st_r.scl_m;
    st_nxt.scl_d = st_r.scl_s;
    st_nxt.sda_m = sda_in;
    st_nxt.sda_s = st_r.sda_m;
    st_nxt.sda_d = st_r.sda_s;
    st_nxt.lvl = DRIVE_LOW;
    st_nxt.to_en = timeout_enable;
    st_nxt.wr_stb = drain;
    if (drain)
    begin
      st_nxt.wr_addr = fifo_out_data[WQ_W-1:REG_W];
      st_nxt.wr_data = fifo_out_data[REG_W-1:0];
    end
    if (st_r.push_v && fifo_in_ready)
      st_nxt.push_v = 1'b0;

    if (!st_r.pwr_done)
    begin
      st_nxt.pwr_cnt = st_r.pwr_cnt + 1'b1;
      if (st_r.pwr_cnt == CNT_W'(POWERUP_CYCLES - 1))
        st_nxt.pwr_done = 1'b1;
    end

    // Saturating timers run only while armed; a late enable still gets a full period
    if (!st_r.scl_s && st_r.to_en && st_r.low_cnt != '1)
      st_nxt.low_cnt = st_r.low_cnt + 1'b1;
    else if (st_r.scl_s || !st_r.to_en)
      st_nxt.low_cnt = '0;
    if (st_r.scl_s && st_r.sda_s && !deepest_sleep_request && st_r.idle_cnt != '1)
      st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
    else if (!(st_r.scl_s && st_r.sda_s) || deepest_sleep_request)
      st_nxt.idle_cnt = '0;

    case (st_r.state)
      ST_IDLE:
      begin
        st_nxt.oe = 1'b0;
      end
      ST_ADDR, ST_REG, ST_WDATA:
      begin
        if (scl_rise)
        begin
          st_nxt.sh = {st_r.sh[6:0], st_r.sda_s};
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
        else if (byte_end)
        begin
          st_nxt.cnt = '0;
          st_nxt.oe = 1'b1;
          if (st_r.state == ST_ADDR)
          begin
            if (addr_hit(st_r.sh[7:1]))
            begin
              st_nxt.rw = st_r.sh[0];
              st_nxt.addressed = 1'b1;
              st_nxt.state = ST_ADDR_ACK;
            end
            else
            begin
              st_nxt.oe = 1'b0;
              st_nxt.state = ST_IGNORE;
            end
          end
          else if (st_r.state == ST_REG)
          begin
            st_nxt.ptr = st_r.sh;
            st_nxt.state = ST_REG_ACK;
          end
          else
          begin
            // A byte still waiting for the queue is overwritten here;
            // only possible if the core stalls through nine writes.
            st_nxt.push_v = 1'b1;
            st_nxt.push_word = {st_r.ptr, st_r.sh};
            st_nxt.ptr = inc_ptr(st_r.ptr);
            st_nxt.state = ST_WDATA_ACK;
          end
        end
      end
      ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK:
      begin
        if (scl_fall)
        begin
          st_nxt.oe = 1'b0;
          st_nxt.cnt = '0;
          if (st_r.state == ST_ADDR_ACK && st_r.rw == RW_READ)
          begin
            st_nxt.sh = mem_rdata;
            st_nxt.oe = !mem_rdata[7];
            st_nxt.state = ST_TX;
          end
          else if (st_r.state == ST_ADDR_ACK)
            st_nxt.state = ST_REG;
          else
            st_nxt.state = ST_WDATA;
        end
      end
      ST_TX:
      begin
        if (scl_fall)
        begin
          if (st_r.cnt == LAST_BIT)
          begin
            st_nxt.oe = 1'b0;
            st_nxt.ptr = inc_ptr(st_r.ptr);
            st_nxt.state = ST_RACK;
          end
          else
          begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            st_nxt.sh = {st_r.sh[6:0], 1'b0};
            st_nxt.oe = !st_r.sh[6];
          end
        end
      end
      ST_RACK:
      begin
        if (scl_rise)
          st_nxt.more = !st_r.sda_s;
        else if (scl_fall)
        begin
          st_nxt.cnt = '0;
          if (st_r.more)
          begin
            st_nxt.sh = mem_rdata;
            st_nxt.oe = !mem_rdata[7];
            st_nxt.state = ST_TX;
          end
          else
          begin
            st_nxt.addressed = 1'b0;
            st_nxt.state = ST_IGNORE;
          end
        end
      end
      ST_IGNORE:
      begin
        st_nxt.oe = 1'b0;
      end
      default:
      begin
        st_nxt.state = ST_IDLE;
      end
    endcase

    // Bus conditions outrank byte handling; a repeated start keeps the pointer
    if (start_ev)
    begin
      st_nxt.state = ST_ADDR;
      st_nxt.cnt = '0;
      st_nxt.oe = 1'b0;
    end
    if (stop_ev || to_fire || idle_fire || !st_r.pwr_done)
    begin
      st_nxt.state = ST_IDLE;
      st_nxt.cnt = '0;
      st_nxt.oe = 1'b0;
      st_nxt.addressed = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.scl_m <= 1'b1;
      st_r.scl_s <= 1'b1;
      st_r.scl_d <= 1'b1;
      st_r.sda_m <= 1'b1;
      st_r.sda_s <= 1'b1;
      st_r.sda_d <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_powerup_quiet: assert property (!st_r.pwr_done |-> !st_r.oe && st_r.state == ST_IDLE)
    else $error("bus answered during power-up quiet time");
  a_powerup_len: assert property ($rose(st_r.pwr_done) |-> $past(st_r.pwr_cnt) == CNT_W'(POWERUP_CYCLES - 1))
    else $error("power-up quiet time has wrong length");
  a_no_stretch: assert property ($rose(st_r.oe) |-> !$past(st_r.scl_s))
    else $error("data drive began while clock high");
  a_start_addr: assert property (start_ev && st_r.pwr_done |=> st_r.state == ST_ADDR && st_r.cnt == '0)
    else $error("start did not open address phase");
  a_dir_capture: assert property (byte_end && st_r.state == ST_ADDR && addr_hit(st_r.sh[7:1])
    |=> st_r.rw == $past(st_r.sh[0]) && st_r.state == ST_ADDR_ACK)
    else $error("direction bit not captured");
  a_addr_ack: assert property (st_r.state == ST_ADDR_ACK |-> st_r.oe && st_r.lvl == DRIVE_LOW)
    else $error("matching address not acknowledged");
  a_tx_msb: assert property (scl_fall && st_r.state == ST_TX && st_r.cnt != LAST_BIT
    |=> st_r.oe == !$past(st_r.sh[6]))
    else $error("transmit bit order wrong");
  a_data_ack: assert property (byte_end && (st_r.state == ST_REG || st_r.state == ST_WDATA)
    |=> st_r.oe && !st_r.lvl)
    else $error("received byte not acknowledged");
  a_stop_idle: assert property (stop_ev |=> st_r.state == ST_IDLE && !st_r.oe && !st_r.addressed)
    else $error("stop did not reset client");
  a_timeout_reset: assert property (to_fire |=> st_r.state == ST_IDLE && !st_r.oe)
    else $error("clock-low time-out did not reset");
  a_timeout_gate: assert property (!$past(timeout_enable) |-> !to_fire)
    else $error("time-out fired while disabled");
  a_idle_reset: assert property (st_r.scl_s && st_r.sda_s && !deepest_sleep_request
    && st_r.idle_cnt == CNT_W'(IDLE_CYCLES - 1) |=> st_r.state == ST_IDLE)
    else $error("idle bus did not reset protocol");
  a_write_ptr: assert property (byte_end && st_r.state == ST_WDATA
    |=> st_r.ptr == inc_ptr($past(st_r.ptr)) && st_r.push_v)
    else $error("write pointer did not advance");
  a_read_ptr: assert property (scl_fall && st_r.state == ST_TX && st_r.cnt == LAST_BIT
    |=> st_r.ptr == inc_ptr($past(st_r.ptr)) && !st_r.oe)
    else $error("read pointer did not advance");
  a_nomatch: assert property (st_r.state == ST_IGNORE |-> !st_r.oe)
    else $error("data driven after address mismatch");
endmodule : smb_client

// [common/smb_client_pkg.sv]
package smb_client_pkg;
  localparam int CLK_MHZ = 100;
  localparam int POWERUP_MS = 10;
  localparam int TIMEOUT_MS = 30;
  localparam int IDLE_US = 150;
  localparam int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int REG_AW = 8;
  localparam int REG_W = 8;
  localparam int WQ_W = REG_AW + REG_W;
  localparam int WQ_DEPTH = 8;
  localparam logic [6:0] ADDR_VARIANT1 = 7'h28;
  localparam logic [6:0] ADDR_VARIANT2 = 7'h2d;
  localparam logic RW_READ = 1'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic DRIVE_LOW = 1'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_TX,
    ST_RACK,
    ST_IGNORE
  } proto_state_t;
endpackage : smb_client_pkg

// [rtl/byte_fifo.sv]
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic in_valid, // Write side offers a word
  output logic in_ready, // FIFO has room
  input wire logic [W-1:0] in_data, // Word to store
  output logic out_valid, // FIFO holds a word
  input wire logic out_ready, // Drain side takes the word
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t st_r;
  fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign in_ready = st_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_r.cnt != '0;
  assign out_data = st_r.mem[st_r.rd];

  // Depth must be a power of two so that the pointers wrap on their own
  always_comb
  begin
    st_nxt = st_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push)
    begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule : byte_fifo

// [rtl/reg_shadow_mem.sv]
`timescale 1ns/100ps
module reg_shadow_mem #(
  parameter int AW = 8,
  parameter int W = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write location
  input wire logic [W-1:0] wr_data, // Write value
  input wire logic [AW-1:0] rd_addr, // Read location
  output logic [W-1:0] rd_data // Registered read value, one cycle late
);
  typedef struct packed {
    logic [(2**AW)-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } mem_st_t;

  mem_st_t st_r;
  mem_st_t st_nxt;

  assign rd_data = st_r.rdata;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = st_r.mem[rd_addr];
    if (wr_en)
      st_nxt.mem[wr_addr] = wr_data;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule : reg_shadow_mem

// [verif/smb_host_model.sv]
`timescale 1ns/100ps
module smb_host_model #(
  parameter int QTR = 2
) (
  input wire logic clk_sys, // Timing reference for host edges
  output logic scl, // Bus clock from the host
  output logic sda_low, // Host pulls the data line low
  input wire logic sda // Resolved data line
);
  int stretch = 0;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // 80 ns bit: the device answers three clocks after a clock fall, one clock before the next rise
  task automatic q(input int n);
    repeat (n * QTR) @(posedge clk_sys);
    #1;
  endtask : q

  task automatic hold(input logic lvl, input int n);
    scl = lvl;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : hold

  task automatic start_cond();
    sda_low = 1'b0;
    q(1);
    scl = 1'b1;
    q(1);
    sda_low = 1'b1;
    q(1);
    scl = 1'b0;
    q(1);
  endtask : start_cond

  task automatic stop_cond();
    scl = 1'b0;
    q(1);
    sda_low = 1'b1;
    q(1);
    scl = 1'b1;
    q(1);
    sda_low = 1'b0;
    q(1);
  endtask : stop_cond

  task automatic clk_bit(input logic drive_low, output logic seen);
    sda_low = drive_low;
    q(1);
    scl = 1'b1;
    q(1);
    seen = sda;
    q(1);
    scl = 1'b0;
    // Low phase lengthened on demand; the device must simply wait
    repeat (stretch) @(posedge clk_sys);
    q(1);
  endtask : clk_bit

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    ack = ~s;
  endtask : write_byte

  task automatic read_byte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(~nack, s);
  endtask : read_byte
endmodule : smb_host_model

// [verif/smb_client_tb.sv]
`timescale 1ns/100ps
module smb_client_tb;
  import smb_client_pkg::*;
  localparam int LIMIT = 60000;
  localparam logic [7:0] AWR = {ADDR_VARIANT1, 1'b0};
  localparam logic [7:0] ARD = {ADDR_VARIANT1, RW_READ};
  localparam logic [7:0] AOTHER = {ADDR_VARIANT2, 1'b0};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic timeout_enable = 1'b0;
  logic deepest_sleep_request = 1'b0;
  logic hold_writes = 1'b0;
  logic scl;
  logic host_low;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic wr_strobe;
  logic [REG_AW-1:0] wr_addr;
  logic [REG_W-1:0] wr_data;
  logic ready;
  logic addressed;
  logic [15:0] wq[$];
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  // Pull-up: a released line reads high
  assign sda = (sda_oe ? sda_out : 1'b1) & ~host_low;

  smb_client #(.POWERUP_CYCLES(200), .TIMEOUT_CYCLES(3000), .IDLE_CYCLES(500)) smb_client_i (
    .clk_sys(clk_sys), .rstn(rstn), .serial_clock_pin(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .timeout_enable(timeout_enable), .deepest_sleep_request(deepest_sleep_request),
    .hold_writes(hold_writes), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .ready(ready), .addressed(addressed));

  smb_host_model smb_host_model_i (.clk_sys(clk_sys), .scl(scl), .sda_low(host_low), .sda(sda));

  always @(posedge clk_sys)
  begin
    if (wr_strobe === 1'b1)
      wq.push_back({wr_addr, wr_data});
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks: %0d, errors: %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    smb_host_model_i.write_byte(b, ack);
    chk(16'(ack), 16'(exp));
  endtask : send

  task automatic recv(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    smb_host_model_i.read_byte(d, nack);
    chk(16'(d), 16'(exp));
  endtask : recv

  task automatic wopen(input logic [7:0] p);
    smb_host_model_i.start_cond();
    send(AWR, 1'b1);
    send(p, 1'b1);
  endtask : wopen

  task automatic ropen(input logic [7:0] p);
    wopen(p);
    smb_host_model_i.start_cond();
    send(ARD, 1'b1);
  endtask : ropen

  task automatic t_powerup();
    int n;
    n = 0;
    chk(16'(ready), 16'h0);
    while (ready !== 1'b1 && n < 400)
    begin
      idle(1);
      n++;
    end
    chk(16'(n > 197 && n < 203), 16'h1);
  endtask : t_powerup

  task automatic t_write_byte();
    wopen(8'h10);
    send(8'ha5, 1'b1);
    smb_host_model_i.stop_cond();
    idle(10);
    chk(16'(wq.size()), 16'h1);
    chk(wq.pop_front(), 16'h10a5);
    chk(16'(addressed), 16'h0);
  endtask : t_write_byte

  task automatic t_block_write();
    hold_writes = 1'b1;
    smb_host_model_i.stretch = 40;
    wopen(8'hfe);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    smb_host_model_i.stop_cond();
    smb_host_model_i.stretch = 0;
    idle(10);
    chk(16'(wq.size()), 16'h0);
    hold_writes = 1'b0;
    idle(10);
    chk(16'(wq.size()), 16'h3);
    chk(wq.pop_front(), 16'hfe11);
    chk(wq.pop_front(), 16'hff22);
    chk(wq.pop_front(), 16'h0033);
  endtask : t_block_write

  task automatic t_reads();
    ropen(8'h10);
    recv(1'b1, 8'ha5);
    smb_host_model_i.stop_cond();
    ropen(8'hfe);
    recv(1'b0, 8'h11);
    recv(1'b0, 8'h22);
    recv(1'b1, 8'h33);
    smb_host_model_i.stop_cond();
    wopen(8'hff);
    smb_host_model_i.stop_cond();
    idle(10);
    chk(16'(wq.size()), 16'h0);
    smb_host_model_i.start_cond();
    send(ARD, 1'b1);
    recv(1'b1, 8'h22);
    smb_host_model_i.stop_cond();
  endtask : t_reads

  task automatic t_wrong_addr();
    smb_host_model_i.start_cond();
    send(AOTHER, 1'b0);
    send(8'h00, 1'b0);
    chk(16'(addressed), 16'h0);
    smb_host_model_i.stop_cond();
  endtask : t_wrong_addr

  task automatic t_idle_reset();
    smb_host_model_i.start_cond();
    send(AWR, 1'b1);
    // Let the device drop its acknowledge before the clock rises, or a stop is seen
    smb_host_model_i.hold(1'b0, 4);
    deepest_sleep_request = 1'b1;
    smb_host_model_i.hold(1'b1, 700);
    chk(16'(addressed), 16'h1);
    deepest_sleep_request = 1'b0;
    smb_host_model_i.hold(1'b1, 700);
    chk(16'(addressed), 16'h0);
    smb_host_model_i.stop_cond();
  endtask : t_idle_reset

  task automatic t_timeout();
    smb_host_model_i.start_cond();
    send(AWR, 1'b1);
    smb_host_model_i.hold(1'b0, 4000);
    chk(16'(addressed), 16'h1);
    timeout_enable = 1'b1;
    smb_host_model_i.hold(1'b0, 3200);
    chk(16'(addressed), 16'h0);
    timeout_enable = 1'b0;
    smb_host_model_i.stop_cond();
  endtask : t_timeout

  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    t_powerup();
    idle(5);
    t_write_byte();
    t_block_write();
    t_reads();
    t_wrong_addr();
    t_idle_reset();
    t_timeout();
    idle(20);
    stop_test();
  end
endmodule : smb_client_tb
